// File: logic/dbmu_pkg.sv
package dbmu_pkg;
  // packet format types
  localparam logic [3:0] FTYPE_DOORBELL = 4'hA;
  localparam logic [3:0] FTYPE_RESPONSE = 4'hD;
  // response status codes
  localparam logic [3:0] ST_DONE = 4'h0;
  localparam logic [3:0] ST_RETRY = 4'h3;
  localparam logic [3:0] ST_ERROR = 4'h7;
  // completion error codes
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_RESP = 2'h1;
  localparam logic [1:0] ERR_TIMEOUT = 2'h2;
  // register byte offsets
  localparam int AW = 8;
  localparam logic [7:0] REG_RX_DATA = 8'h00;
  localparam logic [7:0] REG_RX_STATUS = 8'h04;
  localparam logic [7:0] REG_TX_CTRL = 8'h08;
  localparam logic [7:0] REG_TX_DOORBELL = 8'h0C;
  localparam logic [7:0] REG_TX_STATUS = 8'h10;
  localparam logic [7:0] REG_CMP_DATA = 8'h14;
  localparam logic [7:0] REG_CMP_STATUS = 8'h18;
  localparam logic [7:0] REG_CMP_CTRL = 8'h1C;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h20;
  localparam logic [7:0] REG_IRQ_EN = 8'h24;
  // interrupt status bit positions, output masks and reset values
  localparam int IRQ_RX = 0;
  localparam int IRQ_CMP = 1;
  localparam int IRQ_TMO = 2;
  localparam int IRQ_UNEXP = 3;
  localparam logic [3:0] IRQ_DRB_MASK = 4'h3;
  localparam logic [3:0] IRQ_MNT_MASK = 4'hC;
  localparam logic [3:0] IRQ_RST = 4'h0;
  localparam logic [1:0] PRIO_RST = 2'h0;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // request expiry
  localparam int CLK_MHZ = 25;
  localparam int TMO_US = 1000;
  localparam int TMO_CYC = TMO_US * CLK_MHZ;

  typedef struct packed {
    logic [3:0] ftype;
    logic [1:0] prio;
    logic [7:0] node;
    logic [7:0] tid;
    logic [15:0] info;
    logic [3:0] status;
  } dbmu_pkt_t;
endpackage

// File: logic/dbmu_top.sv
`timescale 1ns/100ps

// ======================================================
// simple synchronous fifo
module dbmu_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic full,
  output logic empty,
  output logic [$clog2(D+1)-1:0] level
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [$clog2(D+1)-1:0] cnt_r;
  assign dout = mem[rp_r];
  assign full = (cnt_r == D[$clog2(D+1)-1:0]);
  assign empty = (cnt_r == '0);
  assign level = cnt_r;
  always_ff @(posedge clk) begin
    if (push && !full) begin
      mem[wp_r] <= din;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push && !full) begin
        wp_r <= PW'((wp_r + 1'b1) % D);
      end
      if (pop && !empty) begin
        rp_r <= PW'((rp_r + 1'b1) % D);
      end
      cnt_r <= cnt_r + (push && !full) - (pop && !empty);
    end
  end
endmodule

// ======================================================
// doorbell message unit
module dbmu_top #(
  parameter int OUT_DEPTH = 16,
  parameter int RX_DEPTH = 16,
  parameter int CMP_DEPTH = 16,
  parameter int ACK_SLOTS = 8,
  parameter int TMO_CYC = dbmu_pkg::TMO_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dbmu_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [dbmu_pkg::AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic tx_pkt_valid,
  input wire logic tx_pkt_ready,
  output dbmu_pkg::dbmu_pkt_t tx_pkt,
  input wire logic rx_pkt_valid,
  output logic rx_pkt_ready,
  input wire dbmu_pkg::dbmu_pkt_t rx_pkt,
  output logic drbell_irq,
  output logic mnt_irq
);
  localparam int SW = $clog2(ACK_SLOTS);
  localparam int PKW = $bits(dbmu_pkg::dbmu_pkt_t);
  localparam int CW = 26;
  localparam int OLW = $clog2(OUT_DEPTH+1);
  localparam int RLW = $clog2(RX_DEPTH+1);
  localparam int CLW = $clog2(CMP_DEPTH+1);

  if (ACK_SLOTS < 2 || ACK_SLOTS > 256 || (1 << SW) != ACK_SLOTS || OUT_DEPTH < 2
      || RX_DEPTH > 255 || OUT_DEPTH > 255 || CMP_DEPTH > 255 || TMO_CYC < 1) begin : g_chk
    $error("dbmu_top: unsupported parameter values");
  end

  function automatic logic dbmu_mapped(input logic [dbmu_pkg::AW-1:0] a);
    dbmu_mapped = (a[1:0] == 2'h0) && (a <= dbmu_pkg::REG_IRQ_EN);
  endfunction

  // ======================================================
  // bus handshake, control, interrupt and transmit state
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_full_r, w_full_r;
  logic [dbmu_pkg::AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [1:0] prio_r;
  logic cap_en_r;
  logic [3:0] irq_st_r, irq_en_r, irq_st_nxt;
  logic drb_irq_r, mnt_irq_r;
  logic rx_ready_r, tx_valid_r;
  dbmu_pkg::dbmu_pkt_t tx_pkt_r;

  // fifo wiring
  logic out_push, out_full, out_empty;
  logic [PKW-1:0] out_din, out_dout;
  logic [OLW-1:0] out_level;
  logic tx_load, tx_req_load;
  logic rx_push, rx_pop, rx_full, rx_empty;
  logic [23:0] rx_dout;
  logic [RLW-1:0] rx_level;
  logic cmp_push, cmp_pop, cmp_full, cmp_empty;
  logic [CW-1:0] cmp_din, cmp_dout;
  logic [CLW-1:0] cmp_level;

  // acknowledge memory
  logic [ACK_SLOTS-1:0] ack_v_r;
  dbmu_pkg::dbmu_pkt_t ack_pkt_r [ACK_SLOTS];
  logic [31:0] ack_age_r [ACK_SLOTS];
  logic [SW-1:0] scan_r;

  wire aw_hs = s_axi_awvalid && awready_r;
  wire w_hs = s_axi_wvalid && wready_r;
  wire b_hs = bvalid_r && s_axi_bready;
  wire ar_hs = s_axi_arvalid && arready_r;
  wire r_hs = rvalid_r && s_axi_rready;

  // ======================================================
  // receive classification
  wire rx_take = rx_pkt_valid && rx_ready_r;
  wire rx_is_req = rx_pkt.ftype == dbmu_pkg::FTYPE_DOORBELL;
  wire rx_is_rsp = rx_pkt.ftype == dbmu_pkg::FTYPE_RESPONSE;
  wire [SW-1:0] rx_slot = rx_pkt.tid[SW-1:0];
  wire rx_tid_ok = (rx_pkt.tid >> SW) == 8'h00;
  wire rx_hit = rx_take && rx_is_rsp && rx_tid_ok && ack_v_r[rx_slot];
  wire rx_retry = rx_hit && rx_pkt.status == dbmu_pkg::ST_RETRY;
  wire rx_done = rx_hit && rx_pkt.status == dbmu_pkg::ST_DONE;
  wire rx_err = rx_hit && !rx_retry && !rx_done;
  wire rx_unexp = rx_take && rx_is_rsp && !(rx_tid_ok && ack_v_r[rx_slot]);
  wire rx_req = rx_take && rx_is_req;
  assign rx_push = rx_req && !rx_full;
  assign rx_pop = ar_hs && s_axi_araddr == dbmu_pkg::REG_RX_DATA;

  // ======================================================
  // doorbell write and output queue arbitration
  wire wr_is_db = awaddr_r == dbmu_pkg::REG_TX_DOORBELL;
  // a full queue leaves the write parked with no bresp; reads stay blocked meanwhile
  wire do_wr = aw_full_r && w_full_r && !(wr_is_db && (out_full || rx_take));
  wire db_wr = do_wr && wr_is_db;
  dbmu_pkg::dbmu_pkt_t rsp_pkt, req_pkt;
  always_comb begin
    rsp_pkt = '0;
    rsp_pkt.ftype = dbmu_pkg::FTYPE_RESPONSE;
    rsp_pkt.prio = rx_pkt.prio;
    rsp_pkt.node = rx_pkt.node;
    rsp_pkt.tid = rx_pkt.tid;
    rsp_pkt.status = rx_full ? dbmu_pkg::ST_RETRY : dbmu_pkg::ST_DONE;
    req_pkt = '0;
    req_pkt.ftype = dbmu_pkg::FTYPE_DOORBELL;
    req_pkt.prio = prio_r;
    req_pkt.node = wdata_r[23:16];
    req_pkt.info = wdata_r[15:0];
  end
  // responses, resends and new requests share the one queue
  assign out_push = rx_req || rx_retry || db_wr;
  assign out_din = rx_req ? rsp_pkt : (rx_retry ? ack_pkt_r[rx_slot] : req_pkt);

  dbmu_fifo #(.W(PKW), .D(OUT_DEPTH)) u_out (
    .clk(aclk), .rst_n(aresetn), .push(out_push), .din(out_din), .pop(tx_load),
    .dout(out_dout), .full(out_full), .empty(out_empty), .level(out_level)
  );
  dbmu_fifo #(.W(24), .D(RX_DEPTH)) u_rx (
    .clk(aclk), .rst_n(aresetn), .push(rx_push), .din({rx_pkt.node, rx_pkt.info}),
    .pop(rx_pop), .dout(rx_dout), .full(rx_full), .empty(rx_empty), .level(rx_level)
  );
  dbmu_fifo #(.W(CW), .D(CMP_DEPTH)) u_cmp (
    .clk(aclk), .rst_n(aresetn), .push(cmp_push), .din(cmp_din), .pop(cmp_pop),
    .dout(cmp_dout), .full(cmp_full), .empty(cmp_empty), .level(cmp_level)
  );

  // ======================================================
  // transmit hand-off and slot allocation
  dbmu_pkg::dbmu_pkt_t head;
  logic free_any;
  logic [SW-1:0] free_idx;
  always_comb begin
    head = out_dout;
    free_any = 1'b0;
    free_idx = '0;
    for (int i = ACK_SLOTS - 1; i >= 0; i--) begin
      if (!ack_v_r[i]) begin
        free_any = 1'b1;
        free_idx = SW'(i);
      end
    end
  end
  wire head_req = head.ftype == dbmu_pkg::FTYPE_DOORBELL;
  // a request waits at the head until a slot frees so its id stays unique
  assign tx_load = !out_empty && (!tx_valid_r || tx_pkt_ready) && (!head_req || free_any);
  assign tx_req_load = tx_load && head_req;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_valid_r <= 1'b0;
      tx_pkt_r <= '0;
    end else if (tx_load) begin
      tx_valid_r <= 1'b1;
      tx_pkt_r <= head;
      if (head_req) begin
        tx_pkt_r.tid <= 8'(free_idx);
      end
    end else if (tx_pkt_ready) begin
      tx_valid_r <= 1'b0;
    end
  end

  // ======================================================
  // expiry scan and completion queue
  wire tmo_hit = ack_v_r[scan_r] && ack_age_r[scan_r] >= 32'(TMO_CYC) && !cmp_full
      && !(rx_hit && rx_slot == scan_r) && !(rx_done && cap_en_r) && !rx_err;
  dbmu_pkg::dbmu_pkt_t cmp_src;
  assign cmp_src = tmo_hit ? ack_pkt_r[scan_r] : ack_pkt_r[rx_slot];
  assign cmp_push = (rx_done && cap_en_r) || rx_err || tmo_hit;
  assign cmp_din = {tmo_hit ? dbmu_pkg::ERR_TIMEOUT :
      (rx_err ? dbmu_pkg::ERR_RESP : dbmu_pkg::ERR_NONE), cmp_src.node, cmp_src.info};
  assign cmp_pop = ar_hs && s_axi_araddr == dbmu_pkg::REG_CMP_DATA;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_v_r <= '0;
      scan_r <= '0;
    end else begin
      scan_r <= scan_r + 1'b1;
      for (int i = 0; i < ACK_SLOTS; i++) begin
        if (tx_req_load && free_idx == SW'(i)) begin
          ack_v_r[i] <= 1'b1;
        end else if ((rx_hit && rx_slot == SW'(i)) || (tmo_hit && scan_r == SW'(i))) begin
          ack_v_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < ACK_SLOTS; i++) begin
      if (tx_req_load && free_idx == SW'(i)) begin
        ack_pkt_r[i] <= head;
        ack_pkt_r[i].tid <= 8'(free_idx);
        ack_age_r[i] <= '0;
      end else if (ack_v_r[i] && ack_age_r[i] < 32'(TMO_CYC)) begin
        ack_age_r[i] <= ack_age_r[i] + 1'b1;
      end
    end
  end

  // room for one more push next cycle on both queues
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_ready_r <= 1'b0;
    end else begin
      rx_ready_r <= (int'(out_level) + 2 <= OUT_DEPTH) && (int'(cmp_level) + 2 <= CMP_DEPTH);
    end
  end

  // ======================================================
  // interrupt status
  always_comb begin
    irq_st_nxt = irq_st_r;
    if (do_wr && awaddr_r == dbmu_pkg::REG_IRQ_STATUS && wstrb_r[0]) begin
      irq_st_nxt = irq_st_nxt & ~wdata_r[3:0];
    end
    if (rx_empty) begin
      irq_st_nxt[dbmu_pkg::IRQ_RX] = 1'b0;
    end
    if (cmp_empty) begin
      irq_st_nxt[dbmu_pkg::IRQ_CMP] = 1'b0;
    end
    // set wins over every clear in the same cycle
    if (rx_push) begin
      irq_st_nxt[dbmu_pkg::IRQ_RX] = 1'b1;
    end
    if (rx_done || rx_err) begin
      irq_st_nxt[dbmu_pkg::IRQ_CMP] = 1'b1;
    end
    if (tmo_hit) begin
      irq_st_nxt[dbmu_pkg::IRQ_TMO] = 1'b1;
    end
    if (rx_unexp) begin
      irq_st_nxt[dbmu_pkg::IRQ_UNEXP] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_r <= dbmu_pkg::IRQ_RST;
      drb_irq_r <= 1'b0;
      mnt_irq_r <= 1'b0;
    end else begin
      irq_st_r <= irq_st_nxt;
      drb_irq_r <= |(irq_st_r & irq_en_r & dbmu_pkg::IRQ_DRB_MASK);
      mnt_irq_r <= |(irq_st_r & irq_en_r & dbmu_pkg::IRQ_MNT_MASK);
    end
  end

  // ======================================================
  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prio_r <= dbmu_pkg::PRIO_RST;
      cap_en_r <= 1'b0;
      irq_en_r <= dbmu_pkg::IRQ_RST;
    end else if (do_wr && wstrb_r[0]) begin
      unique case (awaddr_r)
        dbmu_pkg::REG_TX_CTRL: prio_r <= wdata_r[1:0];
        dbmu_pkg::REG_CMP_CTRL: cap_en_r <= wdata_r[0];
        dbmu_pkg::REG_IRQ_EN: irq_en_r <= wdata_r[3:0];
        default: prio_r <= prio_r;
      endcase
    end
  end

  // ======================================================
  // bus write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= dbmu_pkg::RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (aw_hs) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        awready_r <= 1'b0;
      end else if (!aw_full_r && !bvalid_r) begin
        awready_r <= 1'b1;
      end
      if (w_hs) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        wready_r <= 1'b0;
      end else if (!w_full_r && !bvalid_r) begin
        wready_r <= 1'b1;
      end
      if (do_wr) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= dbmu_mapped(awaddr_r) ? dbmu_pkg::RESP_OKAY : dbmu_pkg::RESP_DECERR;
      end else if (b_hs) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ======================================================
  // bus read channel; held off while any write is in progress
  wire wr_busy = aw_full_r || w_full_r || aw_hs || w_hs;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= dbmu_pkg::RESP_OKAY;
    end else begin
      arready_r <= !ar_hs && !(rvalid_r && !s_axi_rready) && !wr_busy;
      if (ar_hs) begin
        rvalid_r <= 1'b1;
        rresp_r <= dbmu_mapped(s_axi_araddr) ? dbmu_pkg::RESP_OKAY : dbmu_pkg::RESP_DECERR;
        unique case (s_axi_araddr)
          dbmu_pkg::REG_RX_DATA: rdata_r <= rx_empty ? 32'h0 : {8'h00, rx_dout};
          dbmu_pkg::REG_RX_STATUS: rdata_r <= 32'(rx_level);
          dbmu_pkg::REG_TX_CTRL: rdata_r <= {30'h0, prio_r};
          dbmu_pkg::REG_TX_STATUS: rdata_r <= 32'(out_level);
          dbmu_pkg::REG_CMP_DATA: rdata_r <= cmp_empty ? 32'h0 : {6'h00, cmp_dout};
          dbmu_pkg::REG_CMP_STATUS: rdata_r <= {22'h0, cmp_dout[CW-1 -: 2], 8'(cmp_level)};
          dbmu_pkg::REG_CMP_CTRL: rdata_r <= {31'h0, cap_en_r};
          dbmu_pkg::REG_IRQ_STATUS: rdata_r <= {28'h0, irq_st_r};
          dbmu_pkg::REG_IRQ_EN: rdata_r <= {28'h0, irq_en_r};
          default: rdata_r <= 32'h0;
        endcase
      end else if (r_hs) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign tx_pkt_valid = tx_valid_r;
  assign tx_pkt = tx_pkt_r;
  assign rx_pkt_ready = rx_ready_r;
  assign drbell_irq = drb_irq_r;
  assign mnt_irq = mnt_irq_r;

  // ======================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_full_stall;
    aw_full_r && w_full_r && wr_is_db && out_full |=> !bvalid_r;
  endproperty
  a_full_stall: assert property (p_full_stall) else $error("write taken while full");
  property p_db_queue;
    db_wr |=> out_level == $past(out_level) + 1'b1 - OLW'($past(tx_load));
  endproperty
  a_db_queue: assert property (p_db_queue) else $error("doorbell not queued");
  property p_ack_copy;
    tx_req_load |=> tx_valid_r && ack_v_r[tx_pkt_r.tid[SW-1:0]];
  endproperty
  a_ack_copy: assert property (p_ack_copy) else $error("sent request not saved");
  property p_resp_gen;
    rx_req |-> out_push && out_din[PKW-1 -: 4] == dbmu_pkg::FTYPE_RESPONSE
        && out_din[3:0] == (rx_full ? dbmu_pkg::ST_RETRY : dbmu_pkg::ST_DONE);
  endproperty
  a_resp_gen: assert property (p_resp_gen) else $error("bad generated response");
  property p_cmp_clear;
    irq_st_r[dbmu_pkg::IRQ_CMP] && cmp_empty && !rx_done && !rx_err
        |=> !irq_st_r[dbmu_pkg::IRQ_CMP];
  endproperty
  a_cmp_clear: assert property (p_cmp_clear) else $error("completion bit stuck");
  property p_rx_set;
    rx_push |=> irq_st_r[dbmu_pkg::IRQ_RX] ##1 (drbell_irq == irq_en_r[dbmu_pkg::IRQ_RX]
        || irq_st_r[dbmu_pkg::IRQ_CMP]);
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("inbound irq not raised");
  property p_unexp;
    rx_unexp |=> irq_st_r[dbmu_pkg::IRQ_UNEXP];
  endproperty
  a_unexp: assert property (p_unexp) else $error("unexpected response missed");
  property p_tmo;
    tmo_hit |=> irq_st_r[dbmu_pkg::IRQ_TMO] && !cmp_empty
        ##1 (mnt_irq == irq_en_r[dbmu_pkg::IRQ_TMO] || irq_st_r[dbmu_pkg::IRQ_UNEXP]);
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout not reported");
  property p_retry;
    rx_retry |-> out_push ##1 !out_empty;
  endproperty
  a_retry: assert property (p_retry) else $error("retry not resent");
endmodule

// File: sim/dbmu_link_model.sv
`timescale 1ns/100ps
// ======================================================
// transport side: takes outbound packets, offers queued inbound ones
module dbmu_link_model (
  input wire logic aclk,
  input wire logic stall,
  input wire logic tx_pkt_valid,
  output logic tx_pkt_ready,
  input wire dbmu_pkg::dbmu_pkt_t tx_pkt,
  output logic rx_pkt_valid,
  input wire logic rx_pkt_ready,
  output dbmu_pkg::dbmu_pkt_t rx_pkt
);
  dbmu_pkg::dbmu_pkt_t sent_q[$];
  dbmu_pkg::dbmu_pkt_t send_q[$];
  initial begin
    tx_pkt_ready = 1'b0;
    rx_pkt_valid = 1'b0;
    rx_pkt = '0;
  end
  always @(posedge aclk) begin
    if (tx_pkt_valid && tx_pkt_ready) begin
      sent_q.push_back(tx_pkt);
    end
    tx_pkt_ready <= !stall;
    if (rx_pkt_valid && rx_pkt_ready) begin
      void'(send_q.pop_front());
    end
    rx_pkt_valid <= send_q.size() != 0;
    // idle payload flips so a stale packet never looks like a fresh one
    rx_pkt <= (send_q.size() != 0) ? send_q[0] : ~rx_pkt;
  end
endmodule

// File: sim/dbmu_top_tb.sv
`timescale 1ns/100ps
// ======================================================
// register traffic on the slave port, packets through the link model
module dbmu_top_tb;
  logic aclk, aresetn, stall;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic tx_pkt_valid, tx_pkt_ready, rx_pkt_valid, rx_pkt_ready, drbell_irq, mnt_irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, t0;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, wb;
  dbmu_pkg::dbmu_pkt_t tx_pkt, rx_pkt, p;
  int fails, tests_run, i;

  // short expiry keeps the timeout case quick
  dbmu_top #(.TMO_CYC(200)) u_dut (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .tx_pkt_valid, .tx_pkt_ready, .tx_pkt, .rx_pkt_valid,
    .rx_pkt_ready, .rx_pkt, .drbell_irq, .mnt_irq
  );
  dbmu_link_model u_link (
    .aclk, .stall, .tx_pkt_valid, .tx_pkt_ready, .tx_pkt, .rx_pkt_valid, .rx_pkt_ready, .rx_pkt
  );

  always #20 aclk = ~aclk;

  // ======================================================
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error t=%0t got %h expected %h", $time, g, e);
    end
  endtask

  // wr and rd waits are ended only by the watchdog; poll gives up after 200 reads, take after 1000 cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    wb = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n = 0;
    do begin
      rd(a);
      n++;
    end while ((d & m) == 0 && n < 200);
  endtask

  task automatic take();
    int n = 0;
    while (u_link.sent_q.size() == 0 && n < 1000) begin
      @(posedge aclk);
      n++;
    end
    chk(n < 1000, 1);
    p = u_link.sent_q.pop_front();
  endtask

  task automatic rsp(input logic [7:0] t, input logic [3:0] s);
    u_link.send_q.push_back({dbmu_pkg::FTYPE_RESPONSE, 2'h0, 8'h01, t, 16'h0000, s});
  endtask

  task automatic fin(input string s);
    $display("test %0s finished", s);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ======================================================
  // sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    stall = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    fails = 0;
    tests_run = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h28);
    chk(rr, dbmu_pkg::RESP_DECERR);
    wr(8'h28, 32'h0);
    chk(wb, dbmu_pkg::RESP_DECERR);
    rd(dbmu_pkg::REG_TX_STATUS);
    chk(d, 0);
    wr(dbmu_pkg::REG_IRQ_EN, 32'hF);
    chk(wb, dbmu_pkg::RESP_OKAY);
    wr(dbmu_pkg::REG_CMP_CTRL, 32'h1);
    wr(dbmu_pkg::REG_TX_CTRL, 32'h2);
    wr(dbmu_pkg::REG_TX_DOORBELL, 32'h005A1234);
    // the lone request has moved on into the hand-off register
    rd(dbmu_pkg::REG_TX_STATUS);
    chk(d, 0);
    stall <= 1'b0;
    take();
    chk(p.ftype, dbmu_pkg::FTYPE_DOORBELL);
    chk({p.prio, p.node, p.info}, 26'h25A1234);
    rsp(p.tid, dbmu_pkg::ST_DONE);
    poll(dbmu_pkg::REG_CMP_STATUS, 32'hFF);
    chk(d, 1);
    chk(drbell_irq, 1);
    rd(dbmu_pkg::REG_IRQ_STATUS);
    chk(d[1], 1);
    rd(dbmu_pkg::REG_CMP_DATA);
    chk(d, 32'h005A1234);
    rd(dbmu_pkg::REG_IRQ_STATUS);
    chk(d[1], 0);
    fin("send");
    wr(dbmu_pkg::REG_TX_DOORBELL, 32'h00110042);
    take();
    rsp(p.tid, dbmu_pkg::ST_RETRY);
    take();
    chk(p.info, 16'h0042);
    rsp(p.tid, dbmu_pkg::ST_ERROR);
    poll(dbmu_pkg::REG_CMP_STATUS, 32'hFF);
    chk(d, 32'h101);
    rd(dbmu_pkg::REG_CMP_DATA);
    chk(d, 32'h01110042);
    fin("retry");
    wr(dbmu_pkg::REG_TX_DOORBELL, 32'h00220007);
    take();
    poll(dbmu_pkg::REG_IRQ_STATUS, 32'h4);
    chk(d[2], 1);
    rd(dbmu_pkg::REG_CMP_STATUS);
    chk(d, 32'h201);
    chk(mnt_irq, 1);
    rd(dbmu_pkg::REG_CMP_DATA);
    wr(dbmu_pkg::REG_IRQ_STATUS, 32'h4);
    rd(dbmu_pkg::REG_IRQ_STATUS);
    chk(d[2], 0);
    rsp(8'h77, dbmu_pkg::ST_DONE);
    poll(dbmu_pkg::REG_IRQ_STATUS, 32'h8);
    chk(d[3], 1);
    wr(dbmu_pkg::REG_IRQ_STATUS, 32'h8);
    fin("timeout");
    u_link.send_q.push_back({dbmu_pkg::FTYPE_DOORBELL, 2'h0, 8'h33, 8'h05, 16'hBEEF, 4'h0});
    poll(dbmu_pkg::REG_RX_STATUS, 32'hFF);
    chk(d, 1);
    chk(drbell_irq, 1);
    take();
    chk(p.ftype, dbmu_pkg::FTYPE_RESPONSE);
    chk(p.status, dbmu_pkg::ST_DONE);
    rd(dbmu_pkg::REG_RX_DATA);
    chk(d, 32'h0033BEEF);
    rd(dbmu_pkg::REG_IRQ_STATUS);
    chk(d[0], 0);
    fin("inbound");
    wr(dbmu_pkg::REG_CMP_CTRL, 32'h0);
    stall <= 1'b1;
    i = 0;
    do begin
      wr(dbmu_pkg::REG_TX_DOORBELL, i);
      i++;
      rd(dbmu_pkg::REG_TX_STATUS);
    end while (d != 16 && i < 18);
    chk(d, 16);
    fork
      wr(dbmu_pkg::REG_TX_DOORBELL, 32'h00440044);
      begin
        repeat (20) @(posedge aclk);
        chk(s_axi_bvalid, 0);
        stall <= 1'b0;
      end
    join
    i++;
    for (int k = 0; k < i; k++) begin
      take();
      if (k == 0) t0 = p.tid;
      if (k == 1) chk(p.tid !== t0, 1);
      rsp(p.tid, dbmu_pkg::ST_DONE);
    end
    rd(dbmu_pkg::REG_TX_STATUS);
    chk(d, 0);
    fin("full");
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    report_and_stop();
  end
endmodule
